// >>> hcd_host_ctrl.sv
// Host-side driver issuing microcommand sequences to the line controller
//
// The implementer's own choices: the register offsets and register access over APB.
`include "hcd_defs.svh"
module hcd_host_ctrl
  import hcd_pkg::*;
(
  input wire logic mclk, // 100 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic mc_req, // Word strobe to device
  output logic [15:0] mc_word, // Microcommand or data byte
  output logic mc_is_data, // Word carries a data byte
  input wire logic mc_ack, // Device took the word
  input wire logic din_req, // Device offers a byte
  input wire logic [7:0] din_byte, // Byte from device
  input wire logic din_last, // Offered byte is the final one
  output logic din_ack // Host took the byte
);
  logic [10:0] pin_s;
  logic ack_s;
  logic dreq_s;
  logic dlast_s;
  logic [7:0] dbyte_s;

  hcd_sync #(.WIDTH(11)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({mc_ack, din_req, din_last, din_byte}),
    .sync_out(pin_s)
  );

  assign ack_s = pin_s[10];
  assign dreq_s = pin_s[9];
  assign dlast_s = pin_s[8];
  assign dbyte_s = pin_s[7:0];

  // Fixed microcommand table for each operation
  function automatic logic [15:0] seq_word(input logic [3:0] op, input logic [1:0] idx);
    logic [15:0] w;
    w = `HCD_MC_DATA_END;
    case (op)
      HCD_OP_SET_CFG: begin
        case (idx)
          2'd0: w = `HCD_MC_CFG_OPEN;
          2'd1: w = `HCD_MC_CFG;
          2'd2: w = `HCD_MC_DATA_OUT;
          default: w = `HCD_MC_DATA_END;
        endcase
      end
      HCD_OP_RD_STAT: w = (idx == 2'd0) ? `HCD_MC_STAT : `HCD_MC_DATA_IN;
      HCD_OP_XFER_RCV: w = (idx == 2'd0) ? `HCD_MC_XFER_RCV : `HCD_MC_DATA_IN;
      HCD_OP_DISC: w = `HCD_MC_DISC;
      HCD_OP_BREAK: w = `HCD_MC_BREAK;
      HCD_OP_START_RCV: w = `HCD_MC_START_RCV;
      default: begin
        case (idx)
          2'd0: w = (op == HCD_OP_TX_TBL) ? `HCD_MC_TX_TBL :
                    (op == HCD_OP_RX_TBL) ? `HCD_MC_RX_TBL :
                    (op == HCD_OP_SEND) ? `HCD_MC_SEND : `HCD_MC_SEND_RCV;
          2'd1: w = `HCD_MC_DATA_OUT;
          default: w = `HCD_MC_DATA_END;
        endcase
      end
    endcase
    return w;
  endfunction

  // Last code index of each sequence
  function automatic logic [1:0] seq_last(input logic [3:0] op);
    case (op)
      HCD_OP_SET_CFG: return 2'd3;
      HCD_OP_RD_STAT, HCD_OP_XFER_RCV: return 2'd1;
      HCD_OP_DISC, HCD_OP_BREAK, HCD_OP_START_RCV: return 2'd0;
      default: return 2'd2;
    endcase
  endfunction

  // Data phase of each sequence
  function automatic hcd_phase_e seq_phase(input logic [3:0] op);
    case (op)
      HCD_OP_SET_CFG, HCD_OP_TX_TBL, HCD_OP_RX_TBL: return HCD_PH_OUT;
      HCD_OP_SEND, HCD_OP_SEND_RCV: return HCD_PH_OUT;
      HCD_OP_RD_STAT: return HCD_PH_IN_STAT;
      HCD_OP_XFER_RCV: return HCD_PH_IN_LAST;
      default: return HCD_PH_NONE;
    endcase
  endfunction

  hcd_state_e state_ff;
  logic hs_ff;
  logic [1:0] idx_ff;
  logic [8:0] cnt_ff;
  logic [8:0] out_len_ff;
  logic [15:0] rx_cnt_ff;
  logic [3:0] op_ff;
  logic [8:0] len_ff;
  logic [1:0] shift_ff;
  logic [7:0] baddr_ff;
  logic [7:0] buf_ff [256];
  logic done_ff;
  logic err_ff;
  logic tx_ld_ff;
  logic rx_ld_ff;
  logic shift_mode_ff;
  logic mc_req_ff;
  logic [15:0] mc_word_ff;
  logic mc_is_data_ff;
  logic din_ack_ff;
  logic dlast_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // APB decode; each access answers one cycle after penable rises
  wire apb_acc = psel && penable && !pready_ff;
  wire apb_wr = apb_acc && pwrite;
  wire hit_ctrl = (paddr == `HCD_REG_CTRL);
  wire hit_stat = (paddr == `HCD_REG_STATUS);
  wire hit_len = (paddr == `HCD_REG_LEN);
  wire hit_baddr = (paddr == `HCD_REG_BUF_ADDR);
  wire hit_bdata = (paddr == `HCD_REG_BUF_DATA);
  wire hit_any = hit_ctrl | hit_stat | hit_len | hit_baddr | hit_bdata;
  wire busy = (state_ff != HCD_S_IDLE);
  wire [3:0] go_op = pwdata[`HCD_CTRL_OP_LSB +: 4];
  wire go_req = apb_wr && hit_ctrl && pwdata[`HCD_CTRL_GO_BIT];
  wire go_valid = (go_op <= 4'(HCD_OP_SEND_RCV));
  wire start = go_req && !busy && go_valid;
  wire bad_go = go_req && !busy && !go_valid;
  wire buf_wr_sw = apb_wr && hit_bdata && !busy;
  wire [8:0] go_len = (go_op == 4'(HCD_OP_TX_TBL) || go_op == 4'(HCD_OP_RX_TBL)) ?
                      `HCD_TBL_BYTES : len_ff;

  // Handshake events
  wire code_end = (state_ff == HCD_S_CODE) && hs_ff && !ack_s;
  wire code_last = code_end && (idx_ff == seq_last(op_ff));
  wire dout_end = (state_ff == HCD_S_DOUT) && hs_ff && !ack_s;
  wire dout_last = dout_end && (cnt_ff + 9'd1 >= out_len_ff);
  wire din_take = (state_ff == HCD_S_DIN) && !hs_ff && dreq_s;
  wire din_end = (state_ff == HCD_S_DIN) && hs_ff && !dreq_s;
  // Each input end is tied to its own sequence so a long transfer is not cut at six bytes
  wire stat_done = din_end && (seq_phase(op_ff) == HCD_PH_IN_STAT) &&
                   (cnt_ff == `HCD_STAT_BYTES);
  wire last_done = din_end && (seq_phase(op_ff) == HCD_PH_IN_LAST) && dlast_ff;
  wire op_finish = (code_last && seq_phase(op_ff) == HCD_PH_NONE) || dout_last ||
                   stat_done || last_done || (code_last && seq_phase(op_ff) == HCD_PH_OUT &&
                   out_len_ff == 9'd0);
  wire [7:0] out_raw = buf_ff[cnt_ff[7:0]];
  wire force_top = (op_ff == 4'(HCD_OP_TX_TBL)) && shift_mode_ff;
  wire [7:0] out_byte = force_top ? {shift_ff, out_raw[5:0]} : out_raw;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= HCD_S_IDLE;
      hs_ff <= 1'b0;
      idx_ff <= 2'd0;
    end else begin
      case (state_ff)
        HCD_S_IDLE: begin
          hs_ff <= 1'b0;
          idx_ff <= 2'd0;
          if (start) begin
            state_ff <= HCD_S_CODE;
          end
        end
        HCD_S_CODE: begin
          if (!hs_ff && ack_s) begin
            hs_ff <= 1'b1;
          end else if (code_end) begin
            hs_ff <= 1'b0;
            idx_ff <= idx_ff + 2'd1;
            if (op_finish) begin
              state_ff <= HCD_S_IDLE;
            end else if (code_last && seq_phase(op_ff) == HCD_PH_OUT) begin
              state_ff <= HCD_S_DOUT;
            end else if (code_last) begin
              state_ff <= HCD_S_DIN;
            end
          end
        end
        HCD_S_DOUT: begin
          if (!hs_ff && ack_s) begin
            hs_ff <= 1'b1;
          end else if (dout_end) begin
            hs_ff <= 1'b0;
            if (dout_last) begin
              state_ff <= HCD_S_IDLE;
            end
          end
        end
        HCD_S_DIN: begin
          if (din_take) begin
            hs_ff <= 1'b1;
          end else if (din_end) begin
            hs_ff <= 1'b0;
            if (stat_done || last_done) begin
              state_ff <= HCD_S_IDLE;
            end
          end
        end
        default: state_ff <= HCD_S_IDLE;
      endcase
    end
  end

  // Byte counters; the received total keeps counting past the buffer size
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_ff <= 9'd0;
      rx_cnt_ff <= 16'd0;
      out_len_ff <= `HCD_LEN_RESET;
      op_ff <= 4'd0;
      dlast_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= 9'd0;
      rx_cnt_ff <= 16'd0;
      out_len_ff <= go_len;
      op_ff <= go_op;
    end else if (dout_end || din_take) begin
      cnt_ff <= cnt_ff + 9'd1;
      if (din_take) begin
        rx_cnt_ff <= rx_cnt_ff + 16'd1;
        dlast_ff <= dlast_s;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mc_req_ff <= 1'b0;
      mc_word_ff <= 16'h0000;
      mc_is_data_ff <= 1'b0;
      din_ack_ff <= 1'b0;
    end else begin
      mc_req_ff <= ((state_ff == HCD_S_CODE) || (state_ff == HCD_S_DOUT)) && !hs_ff && !ack_s;
      mc_is_data_ff <= (state_ff == HCD_S_DOUT);
      mc_word_ff <= (state_ff == HCD_S_DOUT) ? {8'h00, out_byte} : seq_word(op_ff, idx_ff);
      din_ack_ff <= (state_ff == HCD_S_DIN) && (din_take || (hs_ff && dreq_s));
    end
  end

  // Buffer: software fills it before a send, received bytes land in it
  always_ff @(posedge mclk) begin
    if (buf_wr_sw) begin
      buf_ff[baddr_ff] <= pwdata[7:0];
    end else if (din_take && cnt_ff < `HCD_TBL_BYTES) begin
      buf_ff[cnt_ff[7:0]] <= dbyte_s;
    end
  end

  // Software-visible control and status
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      len_ff <= `HCD_LEN_RESET;
      shift_ff <= `HCD_SHIFT_RESET;
      baddr_ff <= 8'h00;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      if (apb_wr && hit_len && !busy) begin
        len_ff <= (pwdata[8:0] > `HCD_TBL_BYTES) ? `HCD_TBL_BYTES : pwdata[8:0];
      end
      if (apb_wr && hit_ctrl) begin
        shift_ff <= pwdata[`HCD_CTRL_SHIFT_LSB +: 2];
      end
      if (apb_wr && hit_baddr) begin
        baddr_ff <= pwdata[7:0];
      end else if (buf_wr_sw) begin
        baddr_ff <= baddr_ff + 8'h01;
      end
      // Setting wins over a simultaneous write-one clear
      if (op_finish) begin
        done_ff <= 1'b1;
      end else if (apb_wr && hit_stat && pwdata[`HCD_ST_DONE_BIT]) begin
        done_ff <= 1'b0;
      end
      if (bad_go) begin
        err_ff <= 1'b1;
      end else if (apb_wr && hit_stat && pwdata[`HCD_ST_ERR_BIT]) begin
        err_ff <= 1'b0;
      end
    end
  end

  // Mirror of the device's translation and shift state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_ld_ff <= 1'b0;
      rx_ld_ff <= 1'b0;
      shift_mode_ff <= 1'b0;
    end else if (start && go_op == 4'(HCD_OP_SET_CFG)) begin
      tx_ld_ff <= 1'b0;
      rx_ld_ff <= 1'b0;
    end else begin
      if (dout_last && op_ff == 4'(HCD_OP_TX_TBL)) begin
        tx_ld_ff <= 1'b1;
      end
      if (dout_last && op_ff == 4'(HCD_OP_RX_TBL)) begin
        rx_ld_ff <= 1'b1;
      end
      // Five or six data bits turn on shift handling
      if (dout_end && op_ff == 4'(HCD_OP_SET_CFG) && cnt_ff == `HCD_CFG_MODE_IDX) begin
        shift_mode_ff <= (out_raw[7:4] <= 4'h1);
      end
    end
  end

  wire [31:0] stat_word = {rx_cnt_ff, 11'h000, shift_mode_ff, tx_ld_ff & rx_ld_ff, err_ff,
                           done_ff, busy};
  wire [31:0] rd_mux = hit_ctrl ? {18'h00000, shift_ff, 8'h00, op_ff} :
                       hit_stat ? stat_word :
                       hit_len ? {23'h000000, len_ff} :
                       hit_baddr ? {24'h000000, baddr_ff} :
                       hit_bdata ? {24'h000000, buf_ff[baddr_ff]} : 32'h00000000;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= apb_acc;
      pslverr_ff <= apb_acc && !hit_any;
      prdata_ff <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mc_req = mc_req_ff;
  assign mc_word = mc_word_ff;
  assign mc_is_data = mc_is_data_ff;
  assign din_ack = din_ack_ff;
endmodule // hcd_host_ctrl

// >>> hcd_defs.svh
// Offsets, field positions, reset values and microcommand codes for the host command driver
`ifndef HCD_DEFS_SVH
`define HCD_DEFS_SVH

`define HCD_REG_CTRL 8'h00
`define HCD_REG_STATUS 8'h04
`define HCD_REG_LEN 8'h08
`define HCD_REG_BUF_ADDR 8'h0c
`define HCD_REG_BUF_DATA 8'h10

`define HCD_CTRL_OP_LSB 0
`define HCD_CTRL_GO_BIT 8
`define HCD_CTRL_SHIFT_LSB 12

`define HCD_ST_BUSY_BIT 0
`define HCD_ST_DONE_BIT 1
`define HCD_ST_ERR_BIT 2
`define HCD_ST_XLATE_BIT 3
`define HCD_ST_SHIFT_BIT 4
`define HCD_ST_COUNT_LSB 16

`define HCD_LEN_RESET 9'h000
`define HCD_SHIFT_RESET 2'h0

`define HCD_MC_CFG_OPEN 16'h4580
`define HCD_MC_CFG 16'h4402
`define HCD_MC_STAT 16'h4403
`define HCD_MC_TX_TBL 16'h4404
`define HCD_MC_RX_TBL 16'h4405
`define HCD_MC_DISC 16'h4406
`define HCD_MC_BREAK 16'h4407
`define HCD_MC_START_RCV 16'h4408
`define HCD_MC_XFER_RCV 16'h4409
`define HCD_MC_SEND 16'h440a
`define HCD_MC_SEND_RCV 16'h440b
`define HCD_MC_DATA_OUT 16'ha000
`define HCD_MC_DATA_END 16'h440c
`define HCD_MC_DATA_IN 16'hc620

`define HCD_STAT_BYTES 9'h006
`define HCD_TBL_BYTES 9'h100
`define HCD_CFG_MODE_IDX 9'h002

`endif

// >>> hcd_pkg.sv
// Types shared by the host command driver
package hcd_pkg;
  typedef enum logic [3:0] {
    HCD_OP_SET_CFG,
    HCD_OP_RD_STAT,
    HCD_OP_TX_TBL,
    HCD_OP_RX_TBL,
    HCD_OP_DISC,
    HCD_OP_BREAK,
    HCD_OP_START_RCV,
    HCD_OP_XFER_RCV,
    HCD_OP_SEND,
    HCD_OP_SEND_RCV
  } hcd_op_e;

  typedef enum logic [1:0] {
    HCD_PH_NONE,
    HCD_PH_OUT,
    HCD_PH_IN_STAT,
    HCD_PH_IN_LAST
  } hcd_phase_e;

  typedef enum logic [1:0] {
    HCD_S_IDLE,
    HCD_S_CODE,
    HCD_S_DOUT,
    HCD_S_DIN
  } hcd_state_e;
endpackage

// >>> hcd_sync.sv
// Two-flop synchroniser for pin inputs
module hcd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk, // Controller clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Pin level from outside
  output logic [WIDTH-1:0] sync_out // Level safe to read
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // hcd_sync

// >>> hcd_host_ctrl_chk.sv
// Port checker for the host command driver, with its bind
module hcd_chk (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic mc_req, // Word strobe
  input wire logic [15:0] mc_word, // Word value
  input wire logic mc_is_data, // Data byte flag
  input wire logic mc_ack, // Device took word
  input wire logic din_req, // Device offers byte
  input wire logic din_ack // Host took byte
);
  logic req_d_ff;
  logic [15:0] code_ff;
  logic [15:0] nxt_code;
  wire new_code = mc_req && !req_d_ff && !mc_is_data;
  // Remembers the code offered before, so order holds across the handshake
  assign nxt_code = new_code ? mc_word : code_ff;
  always_ff @(posedge mclk) begin
    req_d_ff <= sys_rst ? 1'b0 : mc_req;
    code_ff <= sys_rst ? 16'h0000 : nxt_code;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rdy_lat; psel && penable && !pready |=> pready; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("Access not answered next cycle");
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("Ready held too long");
  property p_idle_data; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle_data: assert property (p_idle_data) else $error("Read data outside answer");
  property p_word_hold; mc_req && !mc_ack |=> mc_req && $stable(mc_word); endproperty
  a_word_hold: assert property (p_word_hold) else $error("Word changed before taken");
  property p_req_drop; $rose(mc_ack) |-> ##[2:4] !mc_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("Strobe not released");
  property p_data_pad; mc_req && mc_is_data |-> mc_word[15:8] == 8'h00; endproperty
  a_data_pad: assert property (p_data_pad) else $error("Data word not padded");
  property p_cfg_ord; new_code && mc_word == 16'h4402 |-> code_ff == 16'h4580; endproperty
  a_cfg_ord: assert property (p_cfg_ord) else $error("Config code out of order");
  property p_in_ord; new_code && mc_word == 16'hc620 |-> code_ff inside {16'h4403, 16'h4409};
  endproperty
  a_in_ord: assert property (p_in_ord) else $error("Input code out of order");
  property p_end_ord; new_code && mc_word == 16'h440c |-> code_ff == 16'ha000; endproperty
  a_end_ord: assert property (p_end_ord) else $error("End code out of order");
  property p_out_ord;
    new_code && mc_word == 16'ha000 |->
      code_ff inside {16'h4402, 16'h4404, 16'h4405, 16'h440a, 16'h440b};
  endproperty
  a_out_ord: assert property (p_out_ord) else $error("Output code out of order");
  property p_din_hold; din_ack && din_req |=> din_ack; endproperty
  a_din_hold: assert property (p_din_hold) else $error("Byte ack dropped early");
  c_cfg: cover property (new_code && mc_word == 16'h4580);
  c_in: cover property (din_req && din_ack);
  c_err: cover property (pslverr);
endmodule // hcd_chk

bind hcd_host_ctrl hcd_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mc_req(mc_req),
  .mc_word(mc_word), .mc_is_data(mc_is_data), .mc_ack(mc_ack), .din_req(din_req),
  .din_ack(din_ack));

// >>> hcd_dev_model.sv
// Behavioural line controller answering the host command driver
module hcd_dev_model (
  input wire logic mclk, // Clock
  input wire logic mc_req, // Word offered
  input wire logic [15:0] mc_word, // Code or data byte
  input wire logic mc_is_data, // Word is a data byte
  output logic mc_ack, // Word taken
  output logic din_req, // Byte offered
  output logic [7:0] din_byte, // Byte to host
  output logic din_last, // Final byte
  input wire logic din_ack // Host took byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words[$];
  logic [7:0] sent[$];
  logic [7:0] rxq[$];
  logic [7:0] cfg[$];
  logic [7:0] rx_xlate_table[$];
  int n_disc;
  int n_brk;
  logic [7:0] stat [0:5];
  logic [15:0] code;
  int dly;
  task automatic give(input logic [7:0] b, input logic l);
    din_req <= 1'b1;
    din_byte <= b;
    din_last <= l;
    sent.push_back(b);
    do @(posedge mclk); while (din_ack !== 1'b1);
    din_req <= 1'b0;
    din_last <= 1'b0;
    // Released line shows the inverse so a late sample cannot match
    din_byte <= ~b;
    do @(posedge mclk); while (din_ack !== 1'b0);
  endtask
  initial begin
    logic [15:0] w;
    logic isd;
    mc_ack = 1'b0;
    din_req = 1'b0;
    din_byte = 8'h5a;
    din_last = 1'b0;
    dly = 0;
    n_disc = 0;
    n_brk = 0;
    code = 16'h0000;
    stat = '{default: 8'h00};
    forever begin
      @(posedge mclk);
      if (mc_req === 1'b1 && mc_ack === 1'b0) begin
        w = mc_word;
        isd = mc_is_data;
        repeat (dly) @(posedge mclk);
        mc_ack <= 1'b1;
        words.push_back(w);
        if (!isd && !(w inside {16'h4580, 16'ha000, 16'h440c, 16'hc620})) code = w;
        if (!isd && w == 16'h4402) begin
          rxq.delete();
          cfg.delete();
          rx_xlate_table.delete();
          stat = '{default: 8'h00};
        end
        if (isd && code == 16'h4405) rx_xlate_table.push_back(w[7:0]);
        if (!isd && w == 16'h4406) n_disc++;
        if (!isd && w == 16'h4407) n_brk++;
        if (!isd && w == 16'h4408) rxq.delete();
        if (isd && code == 16'h4402) cfg.push_back(w[7:0]);
        do @(posedge mclk); while (mc_req !== 1'b0);
        mc_ack <= 1'b0;
        if (!isd && w == 16'hc620 && code == 16'h4403) begin
          stat[3] = 8'(rxq.size());
          for (int i = 0; i < 6; i++) give(stat[i], 1'b0);
          for (int i = 0; i < 3; i++) stat[i] = 8'h00;
        end else if (!isd && w == 16'hc620) begin
          foreach (rxq[i]) give(rxq[i], i == rxq.size() - 1);
          rxq.delete();
        end
      end
    end
  end
endmodule // hcd_dev_model

// >>> hcd_host_ctrl_tb.sv
// Self-checking bench for the host command driver
`include "hcd_defs.svh"
`define HCD_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module hcd_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst, psel, penable, pwrite, pready, pslverr, mc_req, mc_is_data, mc_ack;
  logic din_req, din_last, din_ack, erv;
  logic [7:0] paddr, din_byte;
  logic [31:0] pwdata, prdata, rdv;
  logic [15:0] mc_word;
  logic [31:0] rnd = 32'hc8cf6884;
  logic [7:0] bm [0:255];
  logic [15:0] exp_q[$];
  logic [15:0] seqs [0:9][0:3] = '{'{16'h4580, 16'h4402, 16'ha000, 16'h440c},
    '{16'h4403, 16'hc620, 0, 0}, '{16'h4404, 16'ha000, 16'h440c, 0},
    '{16'h4405, 16'ha000, 16'h440c, 0}, '{16'h4406, 0, 0, 0}, '{16'h4407, 0, 0, 0},
    '{16'h4408, 0, 0, 0}, '{16'h4409, 16'hc620, 0, 0}, '{16'h440a, 16'ha000, 16'h440c, 0},
    '{16'h440b, 16'ha000, 16'h440c, 0}};
  int nseq [0:9] = '{4, 2, 3, 3, 1, 1, 1, 2, 3, 3};
  int fail_count = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  hcd_host_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mc_req(mc_req), .mc_word(mc_word), .mc_is_data(mc_is_data),
    .mc_ack(mc_ack), .din_req(din_req), .din_byte(din_byte), .din_last(din_last),
    .din_ack(din_ack));
  hcd_dev_model dev (.mclk(mclk), .mc_req(mc_req), .mc_word(mc_word),
    .mc_is_data(mc_is_data), .mc_ack(mc_ack), .din_req(din_req), .din_byte(din_byte),
    .din_last(din_last), .din_ack(din_ack));
  function automatic logic [7:0] rbyte();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Entered right after an edge; the idle cycle at the end keeps calls apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, `HCD_REG_STATUS, 32'h0);
      n++;
    end while (rdv[b] !== 1'b1 && n < 5000);
    `HCD_CHK(rdv[b], 1'b1)
  endtask
  task automatic run_op(input int op, input int len);
    int nd;
    dev.words.delete();
    dev.sent.delete();
    exp_q.delete();
    for (int i = 0; i < nseq[op]; i++) exp_q.push_back(seqs[op][i]);
    nd = (op == 2 || op == 3) ? 256 : (op == 0 || op >= 8) ? len : 0;
    for (int i = 0; i < nd; i++) exp_q.push_back({8'h00, bm[i]});
    apb(1'b1, `HCD_REG_LEN, len);
    apb(1'b1, `HCD_REG_CTRL, 32'h100 | op);
    wait_bit(1);
    `HCD_CHK(dev.words.size(), exp_q.size())
    foreach (exp_q[i]) `HCD_CHK(dev.words[i], exp_q[i])
    apb(1'b1, `HCD_REG_STATUS, 32'h6);
  endtask
  task automatic check_in(input int n);
    apb(1'b0, `HCD_REG_STATUS, 32'h0);
    `HCD_CHK(rdv[31:16], 16'(n))
    `HCD_CHK(dev.sent.size(), n)
    for (int i = 0; i < n; i++) begin
      apb(1'b1, `HCD_REG_BUF_ADDR, i);
      apb(1'b0, `HCD_REG_BUF_DATA, 32'h0);
      `HCD_CHK(rdv[7:0], dev.sent[i])
      bm[i] = dev.sent[i];
    end
  endtask
  initial begin
    #900us;
    fail_count++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, `HCD_REG_STATUS, 32'h0);
    `HCD_CHK(rdv, 32'h0)
    apb(1'b0, `HCD_REG_LEN, 32'h0);
    `HCD_CHK(rdv, 32'h0)
    apb(1'b1, 8'h40, 32'h1);
    `HCD_CHK(erv, 1'b1)
    apb(1'b0, 8'h40, 32'h0);
    `HCD_CHK({erv, rdv}, 33'h100000000)
    apb(1'b1, `HCD_REG_BUF_ADDR, 32'h0);
    // Config byte 2 keeps a high nibble of 3 so shift handling stays off
    for (int i = 0; i < 256; i++) begin
      bm[i] = rbyte();
      if (i == 2) bm[i] = {4'h3, bm[i][3:0]};
      apb(1'b1, `HCD_REG_BUF_DATA, {24'h0, bm[i]});
    end
    for (int op = 0; op < 10; op++) begin
      dev.dly = op % 3;
      if (op == 7) repeat (8) dev.rxq.push_back(rbyte());
      run_op(op, op == 0 ? 3 : op == 9 ? {1'b0, rbyte()} : 0);
      if (op == 1 || op == 7) check_in(op == 1 ? 6 : 8);
      if (op < 4) begin
        apb(1'b0, `HCD_REG_STATUS, 32'h0);
        `HCD_CHK(rdv[4:3], {1'b0, op == 3})
      end
    end
    `HCD_CHK(dev.rx_xlate_table.size(), 256)
    `HCD_CHK(dev.n_disc, 1)
    `HCD_CHK(dev.n_brk, 1)
    // A second config load must drop both tables; byte 2 now holds a received value
    run_op(0, 3);
    apb(1'b0, `HCD_REG_STATUS, 32'h0);
    `HCD_CHK(rdv[4:3], {bm[2][7:4] <= 4'h1, 1'b0})
    `HCD_CHK(dev.rx_xlate_table.size(), 0)
    dev.words.delete();
    apb(1'b1, `HCD_REG_CTRL, 32'h10a);
    wait_bit(2);
    `HCD_CHK(dev.words.size(), 0)
    complete_run();
  end
endmodule // hcd_host_ctrl_tb
